// ### hdl/etcs_pkg.sv
package etcs_pkg;
  // stream geometry
  localparam int WORD_W = 64;
  localparam int WORDS = 2;
  localparam int BEAT_W = 128;
  localparam int EMPTY_W = 3;
  localparam int FIFO_DEPTH = 4;
  localparam int MIN_FRAME_BYTES = 9;

  // field positions inside one buffered beat
  localparam int F_DATA_LSB = 0;
  localparam int F_SOP_LSB = 128;
  localparam int F_EOP_LSB = 130;
  localparam int F_EMP_LSB = 132;
  localparam int F_IDLE_LSB = 138;
  localparam int F_ERR_LSB = 140;
  localparam int ENTRY_W = 142;

  // reset and filler values
  localparam logic [1:0] IDLE_BEAT = 2'h3;
  localparam logic [1:0] FLAGS_RST = 2'h0;
  localparam logic [5:0] EMPTY_RST = 6'h00;

  // clocking: nominal link clock in kHz, local clock period, link clock divider
  localparam int TXMAC_KHZ = 312500;
  localparam int CLK_PERIOD_NS = 50;
  localparam int TXCLK_DIV = 2;
endpackage

// ### hdl/etcs_if.sv
`timescale 1ns/10ps
interface etcs_if;
  logic [127:0] din;
  logic [1:0] din_sop;
  logic [1:0] din_eop;
  logic [5:0] din_eop_empty;
  logic [1:0] din_idle;
  logic [1:0] tx_error;
  logic din_req;
  logic clk_txmac;

  modport mac (
    input din, din_sop, din_eop, din_eop_empty, din_idle, tx_error,
    output din_req, clk_txmac
  );

  modport client (
    output din, din_sop, din_eop, din_eop_empty, din_idle, tx_error,
    input din_req, clk_txmac
  );
endinterface

// ### hdl/etcs_client_end.sv
// Overview of operation
// - 128-bit bus, upper word first, big-endian
// - client keeps frames under nine bytes off
// - start only at a word's top byte
// - start flag bit 0 lower, bit 1 upper
// - end flag marks word holding last byte
// - client sets empty count for end words
// - device ignores empty count without end flag
// - client marks idle words per word
// - device drives acceptance output
// - error request at end corrupts packet
// - all port signals on transmit clock; here they are launched on clk, not on clk_txmac
// - device outputs nominal 312.5 MHz clock; here it outputs clk divided by 2, 10 MHz
// - no idle words inside a packet; here a dry buffer sends idle beats and only raises underrun_q
`timescale 1ns/10ps

module etcs_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // fill side
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic ready_q;
  logic push;
  logic pop;

  assign push = in_valid & ready_q;
  assign pop = out_valid & out_ready;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];
  assign in_ready = ready_q;
  assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // ready is registered so the fill side sees a plain flop
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ready_q <= 1'b0;
    end else begin
      wr_q <= push ? ((wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1) : wr_q;
      rd_q <= pop ? ((rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1) : rd_q;
      cnt_q <= cnt_d;
      ready_q <= (cnt_d != (AW+1)'(DEPTH));
    end
  end
endmodule // etcs_fifo

module etcs_client_end #(
  parameter int DEPTH = etcs_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // user beats in
  input wire logic [127:0] usr_data,
  input wire logic [1:0] usr_sop,
  input wire logic [1:0] usr_eop,
  input wire logic [5:0] usr_empty,
  input wire logic [1:0] usr_idle,
  input wire logic [1:0] usr_err,
  input wire logic usr_valid,
  output logic usr_ready,
  // status pulses
  output logic underrun_q,
  output logic runt_drop_q,
  // link
  etcs_if.client lnk
);
  logic [etcs_pkg::ENTRY_W-1:0] f_in;
  logic [etcs_pkg::ENTRY_W-1:0] f_out;
  logic f_valid;
  logic f_ready;
  logic [127:0] h_data;
  logic [1:0] h_sop;
  logic [1:0] h_eop;
  logic [5:0] h_empty;
  logic [1:0] h_idle;
  logic [1:0] h_err;
  logic [1:0] c_sop;
  logic [1:0] c_eop;
  logic [5:0] c_empty;
  logic [1:0] c_idle;
  logic [1:0] c_err;
  logic [1:0] runt;
  logic open_after;
  logic [127:0] din_q;
  logic [1:0] sop_q;
  logic [1:0] eop_q;
  logic [5:0] empty_q;
  logic [1:0] idle_q;
  logic [1:0] err_q;
  logic in_pkt_q;
  logic take;

  // walks the beat upper word first, tracking whether a packet stays open
  function automatic logic pkt_open(input logic open_in, input logic [1:0] s,
                                    input logic [1:0] e);
    logic o;
    o = open_in;
    for (int i = 1; i >= 0; i--) begin
      if (s[i]) begin
        o = 1'b1;
      end
      if (e[i]) begin
        o = 1'b0;
      end
    end
    return o;
  endfunction

  assign f_in = {usr_err, usr_idle, usr_empty, usr_eop, usr_sop, usr_data};

  etcs_fifo #(.W(etcs_pkg::ENTRY_W), .DEPTH(DEPTH)) u_buf (
    .clk(clk),
    .rst_b(rst_b),
    .in_data(f_in),
    .in_valid(usr_valid),
    .in_ready(f_ready),
    .out_data(f_out),
    .out_valid(f_valid),
    .out_ready(lnk.din_req)
  );

  assign usr_ready = f_ready;

  assign h_data = f_out[etcs_pkg::F_DATA_LSB +: 128];
  assign h_sop = f_out[etcs_pkg::F_SOP_LSB +: 2];
  assign h_eop = f_out[etcs_pkg::F_EOP_LSB +: 2];
  assign h_empty = f_out[etcs_pkg::F_EMP_LSB +: 6];
  assign h_idle = f_out[etcs_pkg::F_IDLE_LSB +: 2];
  assign h_err = f_out[etcs_pkg::F_ERR_LSB +: 2];

  // per-word clean-up before the beat goes on the link
  for (genvar z = 0; z < etcs_pkg::WORDS; z++) begin : g_word
    // start and end in one 8-byte word is always shorter than nine bytes
    assign runt[z] = h_sop[z] & h_eop[z] & ~h_idle[z];
    assign c_idle[z] = h_idle[z] | runt[z];
    assign c_sop[z] = h_sop[z] & ~c_idle[z];
    assign c_eop[z] = h_eop[z] & ~c_idle[z];
    // empty count only where the word ends a packet, else zero
    assign c_empty[z*3 +: 3] = c_eop[z] ? h_empty[z*3 +: 3] : 3'h0;
    assign c_err[z] = h_err[z] & c_eop[z];
  end

  assign open_after = pkt_open(in_pkt_q, c_sop, c_eop);
  assign take = lnk.din_req & f_valid;

  // beat registers load on an accepting edge, take an idle beat when din_req finds nothing, and hold while din_req is low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      din_q <= '0;
      sop_q <= etcs_pkg::FLAGS_RST;
      eop_q <= etcs_pkg::FLAGS_RST;
      empty_q <= etcs_pkg::EMPTY_RST;
      idle_q <= etcs_pkg::IDLE_BEAT;
      err_q <= etcs_pkg::FLAGS_RST;
    end else if (take) begin
      din_q <= h_data;
      sop_q <= c_sop;
      eop_q <= c_eop;
      empty_q <= c_empty;
      idle_q <= c_idle;
      err_q <= c_err;
    end else if (lnk.din_req) begin
      // nothing buffered: fill with an idle beat
      din_q <= '0;
      sop_q <= etcs_pkg::FLAGS_RST;
      eop_q <= etcs_pkg::FLAGS_RST;
      empty_q <= etcs_pkg::EMPTY_RST;
      idle_q <= etcs_pkg::IDLE_BEAT;
      err_q <= etcs_pkg::FLAGS_RST;
    end
  end

  // a buffer that runs dry inside a packet breaks the gap-free stream;
  // the user must keep a packet's beats back to back, this only reports it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      in_pkt_q <= 1'b0;
      underrun_q <= 1'b0;
      runt_drop_q <= 1'b0;
    end else begin
      in_pkt_q <= take ? open_after : in_pkt_q;
      underrun_q <= lnk.din_req & ~f_valid & in_pkt_q;
      runt_drop_q <= take & (|runt);
    end
  end

  // all link signals launched on the one shared clock
  assign lnk.din = din_q;
  assign lnk.din_sop = sop_q;
  assign lnk.din_eop = eop_q;
  assign lnk.din_eop_empty = empty_q;
  assign lnk.din_idle = idle_q;
  assign lnk.tx_error = err_q;
endmodule // etcs_client_end

// ### hdl/etcs_mac_end.sv
`timescale 1ns/10ps

module etcs_mac_end #(
  parameter int DEPTH = etcs_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // link
  etcs_if.mac lnk,
  // serialised 64-bit words toward the framer
  output logic [63:0] out_data_q,
  output logic out_sop_q,
  output logic out_eop_q,
  output logic [2:0] out_empty_q,
  output logic out_err_q,
  output logic out_valid_q,
  input wire logic out_ready
);
  logic [etcs_pkg::ENTRY_W-1:0] f_in;
  logic [etcs_pkg::ENTRY_W-1:0] f_out;
  logic f_valid;
  logic f_ready;
  logic f_pop;
  logic accept;
  logic [127:0] h_data;
  logic [1:0] h_sop;
  logic [1:0] h_eop;
  logic [5:0] h_empty;
  logic [1:0] h_idle;
  logic [1:0] h_err;
  logic sel_q;
  logic cur;
  logic load;
  logic clk_div_q;

  // all-idle beats carry nothing, so they are accepted but not stored
  assign accept = f_ready & ~(&lnk.din_idle);
  assign f_in = {lnk.tx_error, lnk.din_idle, lnk.din_eop_empty, lnk.din_eop,
                 lnk.din_sop, lnk.din};

  // ready comes from a flop that already counts the beat now in flight,
  // so an accepted beat always finds a free slot
  etcs_fifo #(.W(etcs_pkg::ENTRY_W), .DEPTH(DEPTH)) u_buf (
    .clk(clk),
    .rst_b(rst_b),
    .in_data(f_in),
    .in_valid(accept),
    .in_ready(f_ready),
    .out_data(f_out),
    .out_valid(f_valid),
    .out_ready(f_pop)
  );

  assign lnk.din_req = f_ready;

  assign h_data = f_out[etcs_pkg::F_DATA_LSB +: 128];
  assign h_sop = f_out[etcs_pkg::F_SOP_LSB +: 2];
  assign h_eop = f_out[etcs_pkg::F_EOP_LSB +: 2];
  assign h_empty = f_out[etcs_pkg::F_EMP_LSB +: 6];
  assign h_idle = f_out[etcs_pkg::F_IDLE_LSB +: 2];
  assign h_err = f_out[etcs_pkg::F_ERR_LSB +: 2];

  // upper word leaves first, idle words are skipped
  assign cur = (!sel_q && !h_idle[1]) ? 1'b1 : 1'b0;
  assign load = f_valid & (~out_valid_q | out_ready);
  assign f_pop = load & (~cur | h_idle[0]);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_q <= 1'b0;
    end else if (load) begin
      sel_q <= cur & ~h_idle[0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_data_q <= '0;
      out_sop_q <= 1'b0;
      out_eop_q <= 1'b0;
      out_empty_q <= 3'h0;
      out_err_q <= 1'b0;
      out_valid_q <= 1'b0;
    end else if (load) begin
      out_data_q <= cur ? h_data[127:64] : h_data[63:0];
      out_sop_q <= h_sop[cur];
      out_eop_q <= h_eop[cur];
      // count is meaningless without the end flag of its own word
      out_empty_q <= h_eop[cur] ? h_empty[cur*3 +: 3] : 3'h0;
      // corruption request only counts on the word that ends the packet
      out_err_q <= h_err[cur] & h_eop[cur];
      out_valid_q <= 1'b1;
    end else if (out_ready) begin
      out_valid_q <= 1'b0;
    end
  end

  // link clock is a divided copy of clk; the nominal rate is not reachable here
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_div_q <= 1'b0;
    end else begin
      clk_div_q <= ~clk_div_q;
    end
  end

  assign lnk.clk_txmac = clk_div_q;
endmodule // etcs_mac_end

// ### verification/etcs_asserts.sv
`timescale 1ns/10ps
module etcs_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // link
  input wire logic [127:0] din,
  input wire logic [1:0] din_sop,
  input wire logic [1:0] din_eop,
  input wire logic [5:0] din_eop_empty,
  input wire logic [1:0] din_idle,
  input wire logic [1:0] tx_error,
  input wire logic din_req,
  input wire logic clk_txmac
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // packet open after upper word, and after whole accepted beat
  logic open_q;
  logic mid_w;
  assign mid_w = (din_sop[1] | open_q) & ~din_eop[1];
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) open_q <= 1'b0;
    else if (din_req) open_q <= (din_sop[0] | mid_w) & ~din_eop[0];
  end
  req_up_a: assert property ($rose(rst_b) |-> ##[0:2] din_req)
    else $error("no acceptance after reset");
  link_hold_a: assert property (!din_req |=> $stable({din, din_sop, din_eop}))
    else $error("link beat changed while refused");
  empty_ign_a: assert property (
    din_eop_empty == (din_eop_empty & {{3{din_eop[1]}}, {3{din_eop[0]}}}))
    else $error("empty count on word without end");
  err_eop_a: assert property ((tx_error & ~din_eop) == 2'h0)
    else $error("error request without end");
  idle_flags_a: assert property (((din_sop | din_eop) & din_idle) == 2'h0)
    else $error("flags on idle word");
  no_runt_a: assert property ((din_sop & din_eop) == 2'h0)
    else $error("short frame on link");
  clk_div_a: assert property (1'b1 |=> clk_txmac != $past(clk_txmac))
    else $error("link clock not toggling");
  no_nest_a: assert property (
    din_req |-> ((open_q & din_sop[1]) | (mid_w & din_sop[0])) == 1'b0)
    else $error("start inside open packet");
  cover property (din_req && din_eop != 2'h0 && tx_error != 2'h0);
  cover property (!din_req && din_idle != 2'h3);
  cover property (din_req && din_sop[0]);
endmodule // etcs_asserts

// ### verification/etcs_tb_top.sv
`timescale 1ns/10ps
module etcs_tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [127:0] u_d = '0;
  logic [1:0] u_sop = '0, u_eop = '0, u_idle = '0, u_err = '0;
  logic [5:0] u_emp = '0;
  logic u_v = 1'b0, o_rdy = 1'b0, saw_full = 1'b0;
  logic u_rdy, runt, undr, o_sop, o_eop, o_err, o_v;
  logic [63:0] o_d;
  logic [2:0] o_emp;
  logic [69:0] exp_q[$];
  int num_errors = 0, n_tests = 0, runts = 0, unds = 0, cyc = 0;
  etcs_if lnk ();
  always #25 clk = ~clk;
  etcs_client_end i_etcs_client_end (.clk(clk), .rst_b(rst_b), .usr_data(u_d),
    .usr_sop(u_sop), .usr_eop(u_eop), .usr_empty(u_emp), .usr_idle(u_idle),
    .usr_err(u_err), .usr_valid(u_v), .usr_ready(u_rdy), .underrun_q(undr),
    .runt_drop_q(runt), .lnk(lnk.client));
  etcs_mac_end i_etcs_mac_end (.clk(clk), .rst_b(rst_b), .lnk(lnk.mac), .out_data_q(o_d),
    .out_sop_q(o_sop), .out_eop_q(o_eop), .out_empty_q(o_emp), .out_err_q(o_err),
    .out_valid_q(o_v), .out_ready(o_rdy));
  etcs_asserts i_etcs_asserts (.clk(clk), .rst_b(rst_b), .din(lnk.din), .din_sop(lnk.din_sop),
    .din_eop(lnk.din_eop), .din_eop_empty(lnk.din_eop_empty), .din_idle(lnk.din_idle),
    .tx_error(lnk.tx_error), .din_req(lnk.din_req), .clk_txmac(lnk.clk_txmac));
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (runt === 1'b1) runts++;
    if (undr === 1'b1) unds++;
    if (u_v && u_rdy === 1'b0 && rst_b) saw_full = 1'b1;
    if (cyc == 3000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic chk_word(input logic [69:0] g, e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %0t word %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_num(input int g, e);
    n_tests++;
    if (g != e) begin
      num_errors++;
      $display("wrong value %0t count %0d expected %0d", $time, g, e);
    end
  endtask
  // distinct halves so a swapped word order shows
  function automatic logic [127:0] bd(input logic [7:0] k);
    return {{8{k}}, {8{~k}}};
  endfunction
  task automatic send(input logic [127:0] d, input logic [1:0] s, e, input logic [5:0] m,
                      input logic [1:0] i, r);
    int t;
    @(negedge clk);
    {u_d, u_sop, u_eop, u_emp, u_idle, u_err, u_v} = {d, s, e, m, i, r, 1'b1};
    t = 0;
    // ready is settled at the falling edge and holds until the next rising one
    while (u_rdy !== 1'b1 && t++ < 200) @(negedge clk);
    @(posedge clk);
    for (int k = 1; k >= 0; k--)
      if (!i[k] && !(s[k] && e[k]))
        exp_q.push_back({d[64*k +: 64], s[k], e[k], e[k] ? m[3*k +: 3] : 3'h0, r[k] & e[k]});
  endtask
  task automatic hush();
    @(negedge clk) u_v = 1'b0;
  endtask
  // st idle cycles before each take, so the output side stalls
  task automatic drain(input int n, st);
    int t;
    repeat (n) begin
      repeat (st) @(negedge clk) o_rdy = 1'b0;
      @(negedge clk) o_rdy = 1'b1;
      t = 0;
      // look at the word while it stands, before the edge that takes it
      while (o_v !== 1'b1 && t++ < 200) @(negedge clk);
      chk_word({o_d, o_sop, o_eop, o_emp, o_err}, exp_q.pop_front());
      @(posedge clk);
    end
    @(negedge clk) o_rdy = 1'b0;
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    send(bd(8'h10), 2'h2, 2'h0, 6'h00, 2'h0, 2'h0);
    send(bd(8'h21), 2'h0, 2'h1, 6'h05, 2'h0, 2'h0);
    send(bd(8'h32), 2'h1, 2'h0, 6'h00, 2'h2, 2'h0);
    send(bd(8'h43), 2'h0, 2'h2, 6'h18, 2'h1, 2'h2);
    hush();
    drain(6, 1);
    $display("test 1 done");
    send(bd(8'h54), 2'h2, 2'h1, 6'h3a, 2'h0, 2'h3);
    hush();
    drain(2, 0);
    $display("test 2 done");
    send(bd(8'h65), 2'h2, 2'h2, 6'h10, 2'h1, 2'h0);
    send(bd(8'h76), 2'h2, 2'h1, 6'h00, 2'h0, 2'h0);
    hush();
    drain(2, 0);
    chk_num(runts, 1);
    $display("test 3 done");
    fork
      begin
        send(bd(8'h80), 2'h2, 2'h0, 6'h00, 2'h0, 2'h0);
        for (int k = 1; k < 11; k++) send(bd(8'h80 + 8'(k)), 2'h0, 2'h0, 6'h00, 2'h0, 2'h0);
        send(bd(8'h8b), 2'h0, 2'h1, 6'h07, 2'h0, 2'h0);
        hush();
      end
      begin
        repeat (30) @(posedge clk);
        drain(24, 2);
      end
    join
    chk_num(int'(saw_full), 1);
    chk_num(unds, 0);
    $display("test 4 done");
    // a gap inside an open packet must be reported as an underrun
    send(bd(8'h90), 2'h2, 2'h0, 6'h00, 2'h0, 2'h0);
    hush();
    repeat (4) @(negedge clk);
    send(bd(8'h91), 2'h0, 2'h1, 6'h00, 2'h0, 2'h0);
    hush();
    drain(4, 0);
    chk_num(int'(unds != 0), 1);
    chk_num(exp_q.size(), 0);
    $display("test 5 done");
    give_verdict();
  end
endmodule // etcs_tb_top
